/* verilog/rivm_pkg.sv */
// Package of constants and types for the reset and interrupt vector map
// Overview of operation
// - All reset sources go to vector zero
// - External requests zero, one to 0x001, 0x002
// - Pin change groups map to 0x003..0x005
// - Watchdog time-out interrupt maps to 0x006
// - Timer two match A, B, overflow 0x007..0x009
// - Wide timer capture, matches, overflow 0x00a..0x00d
// - Timer zero match A, B, overflow 0x00e..0x010
// - SPI transfer complete maps to 0x011
// - USART receive, empty, transmit 0x012..0x014
// - ADC, EEPROM, comparator, two-wire, self-program 0x015..0x019
// - Relocate bit adds boot section start
// - Boot reset fuse sends reset to boot
// - Wake from sleep holds core through start-up and four cycles past it
`default_nettype none
package rivm_pkg;
   localparam int          VEC_W        = 14;
   localparam int          NUM_IRQ      = 25;
   localparam int          IDX_W        = 5;
   localparam logic [13:0] RESET_VECTOR = 14'h0000;
   localparam logic [13:0] FIRST_IRQ_VEC = 14'h0001;
   localparam logic [13:0] BOOT_START_DEF = 14'h1c00;
   localparam logic [2:0]  WAKE_HOLD_CYC = 3'h4;

   // Request bit order equals vector order minus one
   typedef enum logic [4:0] {
      IRQ_EXT_ZERO = 5'h00, IRQ_EXT_ONE = 5'h01,
      IRQ_PC_ZERO = 5'h02, IRQ_PC_ONE = 5'h03, IRQ_PC_TWO = 5'h04,
      IRQ_WDOG_TO = 5'h05,
      IRQ_T2_MA = 5'h06, IRQ_T2_MB = 5'h07, IRQ_T2_OVF = 5'h08,
      IRQ_WT_CAP = 5'h09, IRQ_WT_MA = 5'h0a, IRQ_WT_MB = 5'h0b, IRQ_WT_OVF = 5'h0c,
      IRQ_T0_MA = 5'h0d, IRQ_T0_MB = 5'h0e, IRQ_T0_OVF = 5'h0f,
      IRQ_SPI = 5'h10,
      IRQ_RX = 5'h11, IRQ_TX_EMPTY = 5'h12, IRQ_TX = 5'h13,
      IRQ_ADC = 5'h14, IRQ_EEPROM = 5'h15, IRQ_ACMP = 5'h16, IRQ_TWO_WIRE = 5'h17,
      IRQ_SELF_PROG = 5'h18
   } rivm_irq_t;

   // Request taken by the core
   typedef struct packed {
      logic       valid;
      logic [4:0] index;
   } rivm_req_t;

   // Answer to the core
   typedef struct packed {
      logic        valid;
      logic        is_reset;
      logic [13:0] addr;
   } rivm_vec_t;

   typedef enum logic [1:0] {
      ST_RUN  = 2'b00,
      ST_WAKE = 2'b01,
      ST_HOLD = 2'b11
   } rivm_state_t;
endpackage : rivm_pkg
`default_nettype wire

/* verilog/rivm_vec_calc.sv */
// Combinational vector address former
`timescale 1ns/100ps
`default_nettype none
module rivm_vec_calc #(
   parameter int VEC_W = rivm_pkg::VEC_W
) (
   // Selection
   input  wire logic             is_reset,
   input  wire logic [4:0]       index,
   // Placement controls
   input  wire logic             vector_relocate_bit,
   input  wire logic             boot_reset_fuse,
   input  wire logic [VEC_W-1:0] boot_start,
   // Result
   output logic      [VEC_W-1:0] addr
);
   // Narrower than the index would fold table entries together
   if (VEC_W < 5) begin : g_bad_width
      $error("VEC_W too narrow for the vector table");
   end

   logic [VEC_W-1:0] base;

   // Table position plus optional boot offset
   always_comb begin
      base = VEC_W'(rivm_pkg::FIRST_IRQ_VEC) + VEC_W'(index);
      if (is_reset) begin
         addr = boot_reset_fuse ? boot_start : VEC_W'(rivm_pkg::RESET_VECTOR);
      end else begin
         addr = vector_relocate_bit ? VEC_W'(base + boot_start) : base;
      end
   end
endmodule : rivm_vec_calc
`default_nettype wire

/* verilog/rivm_top.sv */
// Reset and interrupt vector map with wake hold
`timescale 1ns/100ps
`default_nettype none
module rivm_top #(
   parameter int VEC_W = rivm_pkg::VEC_W
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                resetn,
   // Reset causes, one-cycle pulses or levels
   input  wire logic                rst_pin,
   input  wire logic                rst_por,
   input  wire logic                rst_bod,
   input  wire logic                rst_watchdog,
   // Interrupt request taken by the core
   input  wire rivm_pkg::rivm_req_t irq_req,
   // Sleep and wake
   input  wire logic                asleep,
   input  wire logic                wake_done,
   // Placement controls
   input  wire logic                vector_relocate_bit,
   input  wire logic                boot_reset_fuse,
   input  wire logic [VEC_W-1:0]    boot_start,
   // Answer to the core
   output var rivm_pkg::rivm_vec_t  vec_out,
   output logic                     core_hold
);
   // Answer struct fixes the address at 14 bits
   if (VEC_W != 14) begin : g_bad_width
      $error("VEC_W must be 14 to match the answer struct");
   end

   logic                  any_reset;
   logic                  req_ok;
   logic                  take_plain;
   logic [VEC_W-1:0]      addr_c;
   logic [4:0]            pend_idx_q;
   logic                  pend_q;
   logic [2:0]            cnt_q;
   rivm_pkg::rivm_state_t state_q;
   rivm_pkg::rivm_vec_t   vec_q;
   logic                  hold_q;

   // Any cause resets; indices past the table are dropped
   assign any_reset  = rst_pin | rst_por | rst_bod | rst_watchdog;
   assign req_ok     = irq_req.valid && (irq_req.index < 5'(rivm_pkg::NUM_IRQ));
   // Awake, unrelocated request taken in run state, for the checks
   assign take_plain = req_ok && !asleep && !any_reset && !vector_relocate_bit
                       && state_q == rivm_pkg::ST_RUN;

   rivm_vec_calc #(.VEC_W(VEC_W)) u_calc (
      .is_reset            (any_reset),
      .index               (state_q == rivm_pkg::ST_HOLD ? pend_idx_q : irq_req.index),
      .vector_relocate_bit (vector_relocate_bit),
      .boot_reset_fuse     (boot_reset_fuse),
      .boot_start          (boot_start),
      .addr                (addr_c)
   );

   // Wake sequencing: hold core four cycles past start-up
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q    <= rivm_pkg::ST_RUN;
         cnt_q      <= 3'h0;
         pend_q     <= 1'b0;
         pend_idx_q <= 5'h00;
      end else if (any_reset) begin
         state_q <= rivm_pkg::ST_RUN; // Reset wins over any wake
         pend_q  <= 1'b0;
      end else begin
         unique case (state_q)
            rivm_pkg::ST_RUN: begin
               if (asleep && req_ok) begin
                  state_q    <= rivm_pkg::ST_WAKE;
                  pend_q     <= 1'b1;
                  pend_idx_q <= irq_req.index;
               end
            end
            rivm_pkg::ST_WAKE: begin
               if (wake_done) begin
                  state_q <= rivm_pkg::ST_HOLD;
                  cnt_q   <= rivm_pkg::WAKE_HOLD_CYC - 3'h1;
               end
            end
            rivm_pkg::ST_HOLD: begin
               if (cnt_q == 3'h0) begin
                  state_q <= rivm_pkg::ST_RUN;
                  pend_q  <= 1'b0;
               end else begin
                  cnt_q <= cnt_q - 3'h1;
               end
            end
            default: begin
               state_q <= rivm_pkg::ST_RUN; // Unused code falls back to run
               pend_q  <= 1'b0;
            end
         endcase
      end
   end

   // Core hold: asleep-wake and the four extra cycles
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hold_q <= 1'b0;
      end else begin
         hold_q <= !any_reset && ((state_q == rivm_pkg::ST_RUN && asleep && req_ok)
                   || state_q == rivm_pkg::ST_WAKE
                   || (state_q == rivm_pkg::ST_HOLD && cnt_q != 3'h0));
      end
   end

   // Registered vector, one cycle after an awake request; a sleep request answers at wake release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         vec_q <= '0;
      end else begin
         vec_q.valid    <= any_reset || (req_ok && !asleep && state_q == rivm_pkg::ST_RUN)
                           || (state_q == rivm_pkg::ST_HOLD && cnt_q == 3'h0);
         vec_q.is_reset <= any_reset;
         vec_q.addr     <= addr_c;
      end
   end

   assign vec_out   = vec_q;
   assign core_hold = hold_q;

   // Assertions
   property p_reset_vec;
      @(posedge clk) disable iff (!resetn)
      any_reset && !boot_reset_fuse |=> vec_out.valid && vec_out.addr == '0;
   endproperty
   a_reset_vec: assert property (p_reset_vec) else $error("reset not at vector zero");

   property p_boot_reset;
      @(posedge clk) disable iff (!resetn)
      any_reset && boot_reset_fuse |=> vec_out.addr == $past(boot_start);
   endproperty
   a_boot_reset: assert property (p_boot_reset) else $error("boot reset address wrong");

   property p_irq_vec;
      @(posedge clk) disable iff (!resetn)
      req_ok && !asleep && !any_reset && !vector_relocate_bit && state_q == rivm_pkg::ST_RUN
      |=> vec_out.valid && vec_out.addr == VEC_W'($past(irq_req.index)) + 14'h0001;
   endproperty
   a_irq_vec: assert property (p_irq_vec) else $error("interrupt vector wrong");

   property p_wdog_vec;
      @(posedge clk) disable iff (!resetn)
      req_ok && irq_req.index == rivm_pkg::IRQ_WDOG_TO && !asleep && !any_reset
      && !vector_relocate_bit && state_q == rivm_pkg::ST_RUN |=> vec_out.addr == 14'h0006;
   endproperty
   a_wdog_vec: assert property (p_wdog_vec) else $error("watchdog vector wrong");

   property p_self_prog_vec;
      @(posedge clk) disable iff (!resetn)
      req_ok && irq_req.index == rivm_pkg::IRQ_SELF_PROG && !asleep && !any_reset
      && !vector_relocate_bit && state_q == rivm_pkg::ST_RUN |=> vec_out.addr == 14'h0019;
   endproperty
   a_self_prog_vec: assert property (p_self_prog_vec) else $error("self-program vector wrong");

   property p_reloc;
      @(posedge clk) disable iff (!resetn)
      req_ok && !asleep && !any_reset && vector_relocate_bit && state_q == rivm_pkg::ST_RUN
      |=> vec_out.addr == VEC_W'($past(boot_start) + VEC_W'($past(irq_req.index)) + 14'h0001);
   endproperty
   a_reloc: assert property (p_reloc) else $error("relocated vector wrong");

   sequence s_hold_start;
      state_q == rivm_pkg::ST_WAKE && wake_done && !any_reset;
   endsequence
   property p_wake_hold;
      @(posedge clk) disable iff (!resetn)
      s_hold_start ##1 !any_reset [*4] |=> !core_hold && vec_out.valid && !vec_out.is_reset;
   endproperty
   a_wake_hold: assert property (p_wake_hold) else $error("wake hold not four cycles");

   property p_hold_mid;
      @(posedge clk) disable iff (!resetn)
      s_hold_start ##1 !any_reset [*3] |-> core_hold;
   endproperty
   a_hold_mid: assert property (p_hold_mid) else $error("core released early");

   property p_one_cycle;
      @(posedge clk) disable iff (!resetn)
      any_reset |=> vec_out.valid && vec_out.is_reset;
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("vector late");

   // Table entries at the ends of each group
   property p_vec_01;
      @(posedge clk) disable iff (!resetn)
      take_plain && irq_req.index == rivm_pkg::IRQ_EXT_ZERO |=> vec_out.addr == 14'h0001;
   endproperty
   a_vec_01: assert property (p_vec_01) else $error("vector 0x001 wrong");

   property p_vec_02;
      @(posedge clk) disable iff (!resetn)
      take_plain && irq_req.index == rivm_pkg::IRQ_EXT_ONE |=> vec_out.addr == 14'h0002;
   endproperty
   a_vec_02: assert property (p_vec_02) else $error("vector 0x002 wrong");

   property p_vec_03;
      @(posedge clk) disable iff (!resetn)
      take_plain && irq_req.index == rivm_pkg::IRQ_PC_ZERO |=> vec_out.addr == 14'h0003;
   endproperty
   a_vec_03: assert property (p_vec_03) else $error("vector 0x003 wrong");

   property p_vec_05;
      @(posedge clk) disable iff (!resetn)
      take_plain && irq_req.index == rivm_pkg::IRQ_PC_TWO |=> vec_out.addr == 14'h0005;
   endproperty
   a_vec_05: assert property (p_vec_05) else $error("vector 0x005 wrong");

   property p_vec_07;
      @(posedge clk) disable iff (!resetn)
      take_plain && irq_req.index == rivm_pkg::IRQ_T2_MA |=> vec_out.addr == 14'h0007;
   endproperty
   a_vec_07: assert property (p_vec_07) else $error("vector 0x007 wrong");

   property p_vec_09;
      @(posedge clk) disable iff (!resetn)
      take_plain && irq_req.index == rivm_pkg::IRQ_T2_OVF |=> vec_out.addr == 14'h0009;
   endproperty
   a_vec_09: assert property (p_vec_09) else $error("vector 0x009 wrong");

   property p_vec_0a;
      @(posedge clk) disable iff (!resetn)
      take_plain && irq_req.index == rivm_pkg::IRQ_WT_CAP |=> vec_out.addr == 14'h000a;
   endproperty
   a_vec_0a: assert property (p_vec_0a) else $error("vector 0x00a wrong");

   property p_vec_0d;
      @(posedge clk) disable iff (!resetn)
      take_plain && irq_req.index == rivm_pkg::IRQ_WT_OVF |=> vec_out.addr == 14'h000d;
   endproperty
   a_vec_0d: assert property (p_vec_0d) else $error("vector 0x00d wrong");

   property p_vec_0e;
      @(posedge clk) disable iff (!resetn)
      take_plain && irq_req.index == rivm_pkg::IRQ_T0_MA |=> vec_out.addr == 14'h000e;
   endproperty
   a_vec_0e: assert property (p_vec_0e) else $error("vector 0x00e wrong");

   property p_vec_10;
      @(posedge clk) disable iff (!resetn)
      take_plain && irq_req.index == rivm_pkg::IRQ_T0_OVF |=> vec_out.addr == 14'h0010;
   endproperty
   a_vec_10: assert property (p_vec_10) else $error("vector 0x010 wrong");

   property p_vec_11;
      @(posedge clk) disable iff (!resetn)
      take_plain && irq_req.index == rivm_pkg::IRQ_SPI |=> vec_out.addr == 14'h0011;
   endproperty
   a_vec_11: assert property (p_vec_11) else $error("vector 0x011 wrong");

   property p_vec_12;
      @(posedge clk) disable iff (!resetn)
      take_plain && irq_req.index == rivm_pkg::IRQ_RX |=> vec_out.addr == 14'h0012;
   endproperty
   a_vec_12: assert property (p_vec_12) else $error("vector 0x012 wrong");

   property p_vec_14;
      @(posedge clk) disable iff (!resetn)
      take_plain && irq_req.index == rivm_pkg::IRQ_TX |=> vec_out.addr == 14'h0014;
   endproperty
   a_vec_14: assert property (p_vec_14) else $error("vector 0x014 wrong");

   property p_vec_15;
      @(posedge clk) disable iff (!resetn)
      take_plain && irq_req.index == rivm_pkg::IRQ_ADC |=> vec_out.addr == 14'h0015;
   endproperty
   a_vec_15: assert property (p_vec_15) else $error("vector 0x015 wrong");

   // Refused requests leave no answer
   property p_bad_index;
      @(posedge clk) disable iff (!resetn)
      irq_req.valid && !req_ok && !any_reset && state_q != rivm_pkg::ST_HOLD
      |=> !vec_out.valid;
   endproperty
   a_bad_index: assert property (p_bad_index) else $error("answered bad index");

   // A reset cause drops any wake in progress
   property p_reset_abort;
      @(posedge clk) disable iff (!resetn)
      any_reset |=> !core_hold && !pend_q && state_q == rivm_pkg::ST_RUN;
   endproperty
   a_reset_abort: assert property (p_reset_abort) else $error("wake not aborted");

   // Request while asleep holds the core, no answer yet
   property p_sleep_take;
      @(posedge clk) disable iff (!resetn)
      req_ok && asleep && !any_reset && state_q == rivm_pkg::ST_RUN
      |=> core_hold && pend_q && state_q == rivm_pkg::ST_WAKE && !vec_out.valid;
   endproperty
   a_sleep_take: assert property (p_sleep_take) else $error("sleep request not held");

   // Pending flag marks every state but run
   property p_pend_state;
      @(posedge clk) disable iff (!resetn)
      pend_q == (state_q != rivm_pkg::ST_RUN);
   endproperty
   a_pend_state: assert property (p_pend_state) else $error("pending flag wrong");

   // Requests during start-up neither answer nor replace the stored one
   property p_busy_refuse;
      @(posedge clk) disable iff (!resetn)
      req_ok && !any_reset && state_q == rivm_pkg::ST_WAKE
      |=> !vec_out.valid && pend_idx_q == $past(pend_idx_q);
   endproperty
   a_busy_refuse: assert property (p_busy_refuse) else $error("request taken in wake");

   // Release answers with the stored request's vector
   property p_hold_vec_idx;
      @(posedge clk) disable iff (!resetn)
      state_q == rivm_pkg::ST_HOLD && cnt_q == 3'h0 && !any_reset
      |=> vec_out.valid && vec_out.addr == VEC_W'(($past(vector_relocate_bit)
          ? $past(boot_start) : 14'h0000) + VEC_W'($past(pend_idx_q)) + 14'h0001);
   endproperty
   a_hold_vec_idx: assert property (p_hold_vec_idx) else $error("wake vector wrong");
endmodule : rivm_top
`default_nettype wire

/* tb/rivm_core_model.sv */
// Core-side model: start-up delay and program counter
`timescale 1ns/100ps
`default_nettype none
module rivm_core_model #(
   parameter int STARTUP_CYC = 6
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                resetn,
   // From the block
   input  wire rivm_pkg::rivm_vec_t vec_out,
   input  wire logic                core_hold,
   // To the block and bench
   output logic                     wake_done,
   output logic [13:0]              pc_q
);
   int cnt_q;
   // Start-up runs only while held, so wake is never early
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q     <= 0;
         wake_done <= 1'b0;
      end else begin
         cnt_q     <= core_hold ? cnt_q + 1 : 0;
         wake_done <= core_hold && (cnt_q >= STARTUP_CYC);
      end
   end
   // Fetch jumps to each answered vector
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) pc_q <= 14'h0000;
      else if (vec_out.valid) pc_q <= vec_out.addr;
   end
endmodule : rivm_core_model
`default_nettype wire

/* tb/reset_interrupt_vector_map_test.sv */
// Self-checking bench for the vector map
`timescale 1ns/100ps
`default_nettype none
module reset_interrupt_vector_map_test;
   logic                clk = 1'b0, resetn = 1'b0, asleep = 1'b0, relo = 1'b0, fuse = 1'b0;
   logic [3:0]          rc = 4'h0;
   logic [13:0]         bstart = rivm_pkg::BOOT_START_DEF;
   rivm_pkg::rivm_req_t irq_req = '0;
   rivm_pkg::rivm_vec_t vec_out;
   logic                core_hold, wake_done;
   logic [13:0]         pc_q;
   logic [4:0]          idx;
   int                  seed = 58, n_fail = 0, compares = 0, n, i;

   always #5 clk = ~clk;

   rivm_top DUT (.clk(clk), .resetn(resetn), .rst_pin(rc[0]), .rst_por(rc[1]),
      .rst_bod(rc[2]), .rst_watchdog(rc[3]), .irq_req(irq_req), .asleep(asleep),
      .wake_done(wake_done), .vector_relocate_bit(relo), .boot_reset_fuse(fuse),
      .boot_start(bstart), .vec_out(vec_out), .core_hold(core_hold));
   rivm_core_model core (.clk(clk), .resetn(resetn), .vec_out(vec_out),
      .core_hold(core_hold), .wake_done(wake_done), .pc_q(pc_q));

   // Expected target, reset or interrupt
   function automatic logic [13:0] exp_addr(input logic rs, input logic [4:0] ix);
      if (rs) return fuse ? bstart : rivm_pkg::RESET_VECTOR;
      return 14'(ix) + 14'h0001 + (relo ? bstart : 14'h0000);
   endfunction : exp_addr

   task automatic fail(input string m);
      n_fail++;
      $display("mismatch at %0t: %s", $time, m);
   endtask : fail

   task automatic chk_bit(input logic g, input logic e, input string m);
      compares++;
      if (g !== e) fail(m);
   endtask : chk_bit

   task automatic chk_vec(input logic rs, input logic [4:0] ix);
      compares++;
      if (vec_out.is_reset !== rs || vec_out.addr !== exp_addr(rs, ix)) fail("vector");
   endtask : chk_vec

   // One request held for one edge
   task automatic send(input logic [3:0] c, input logic [4:0] ix);
      @(posedge clk);
      rc <= c;
      irq_req <= '{valid: 1'b1, index: ix};
      @(posedge clk);
      rc <= 4'h0;
      irq_req.valid <= 1'b0;
   endtask : send

   // Bounded wait for the answer pulse
   task automatic await_vec(input int lim, output int k);
      k = 0;
      #1;
      while (vec_out.valid !== 1'b1 && k < lim) begin
         @(posedge clk);
         #1;
         k++;
      end
   endtask : await_vec

   // Random controls, then one request
   task automatic shot(input logic [3:0] c, input logic [4:0] ix);
      @(posedge clk);
      relo <= 1'($random(seed));
      fuse <= 1'($random(seed));
      bstart <= 14'($random(seed)) & 14'h3f00;
      send(c, ix);
      await_vec(3, n);
   endtask : shot

   task automatic conclude;
      $display("counts: %0d compares, %0d mismatches", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   initial begin
      #400000;
      fail("timeout");
      conclude();
   end

   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      // Every source first, then random ones
      for (i = 0; i < 120; i++) begin
         idx = (i < 25) ? 5'(i) : 5'($unsigned($random(seed)) % 25);
         shot(4'h0, idx);
         chk_bit(vec_out.valid, 1'b1, "no answer");
         chk_vec(1'b0, idx);
      end
      $display("interrupt vectors done");
      // Each reset cause, with a competing interrupt
      for (i = 0; i < 8; i++) begin
         shot(4'h1 << (i % 4), 5'($unsigned($random(seed)) % 25));
         chk_vec(1'b1, 5'h00);
      end
      $display("reset vectors done");
      // Indices past the table get no answer
      for (i = 25; i < 32; i++) begin
         shot(4'h0, 5'(i));
         chk_bit(vec_out.valid, 1'b0, "answered bad index");
      end
      $display("bad indices done");
      // Wake from sleep holds the core
      @(posedge clk);
      asleep <= 1'b1;
      send(4'h0, 5'h0b);
      #1;
      chk_bit(core_hold, 1'b1, "not held");
      send(4'h0, 5'h03);
      n = 0;
      while (wake_done !== 1'b1 && n < 50) begin
         @(posedge clk);
         #1;
         n++;
      end
      await_vec(8, n);
      chk_bit(n == int'(rivm_pkg::WAKE_HOLD_CYC) + 1, 1'b1, "hold length");
      chk_bit(core_hold, 1'b0, "hold kept");
      chk_vec(1'b0, 5'h0b);
      @(posedge clk);
      asleep <= 1'b0;
      #1;
      chk_bit(pc_q === exp_addr(1'b0, 5'h0b), 1'b1, "fetch address");
      $display("wake done");
      // Reset cause in mid-wake aborts it
      @(posedge clk);
      asleep <= 1'b1;
      send(4'h0, 5'h02);
      send(4'h2, 5'h00);
      await_vec(3, n);
      chk_bit(vec_out.valid, 1'b1, "no reset answer");
      chk_vec(1'b1, 5'h00);
      chk_bit(core_hold, 1'b0, "wake not aborted");
      @(posedge clk);
      asleep <= 1'b0;
      $display("wake abort done");
      conclude();
   end
endmodule : reset_interrupt_vector_map_test
`default_nettype wire
